// [design/stlc_pkg.sv]
// Package with register map, field layout, reset values and carrier types of the transmit lane control bank.
package stlc_pkg;

	// ----------------------------------------------------------------
	// Bus geometry and register offsets
	// ----------------------------------------------------------------
	localparam int unsigned STLC_ADDR_W = 4;
	localparam int unsigned STLC_DATA_W = 32;
	localparam int unsigned STLC_STRB_W = STLC_DATA_W / 8;
	localparam logic [STLC_ADDR_W-1:0] STLC_OFS_LANE_CTRL = 4'h0;
	localparam logic [STLC_ADDR_W-1:0] STLC_OFS_SLEW_BOOST = 4'h4;
	localparam logic [STLC_ADDR_W-1:0] STLC_OFS_VOLT_DEEMPH = 4'h8;
	localparam logic [STLC_ADDR_W-1:0] STLC_OFS_STATUS = 4'hc;
	localparam int unsigned STLC_WORD_LSB = 2;
	localparam logic [1:0] STLC_RESP_OKAY = 2'h0;
	localparam logic [1:0] STLC_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned STLC_LANE_SEL_W = 4;
	localparam int unsigned STLC_LANE_SEL_LSB = 0;
	localparam int unsigned STLC_RATE2_BIT = 4;
	localparam int unsigned STLC_DEEMPH_SEL_BIT = 5;
	localparam int unsigned STLC_LOW_SWING_BIT = 6;
	localparam int unsigned STLC_FSLEW2_LSB = 23;
	localparam int unsigned STLC_SLEW_DIS_BIT = 26;
	localparam int unsigned STLC_BOOST_LSB = 27;
	localparam int unsigned STLC_LVL1_LSB = 0;
	localparam int unsigned STLC_DEEMPH1_LSB = 5;
	localparam int unsigned STLC_LVL2_LSB = 8;
	localparam int unsigned STLC_ST_LEVEL_LSB = 0;
	localparam int unsigned STLC_ST_DEEMPH_LSB = 5;
	localparam int unsigned STLC_ST_FSLEW_LSB = 8;
	localparam int unsigned STLC_ST_BOOST_LSB = 11;
	localparam int unsigned STLC_ST_DEEMPH_EN_BIT = 13;
	localparam int unsigned STLC_ST_SLEW_MAX_BIT = 14;
	localparam int unsigned STLC_ST_LEVEL_APPLY_BIT = 15;
	localparam int unsigned STLC_ST_FSLEW_APPLY_BIT = 16;
	localparam int unsigned STLC_ST_DEEMPH_APPLY_BIT = 17;
	localparam logic STLC_DEEMPH_3P5DB = 1'b1;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic low_swing;
		logic deemph_select;
		logic rate2;
		logic [STLC_LANE_SEL_W-1:0] lane_select;
	} stlc_ctrl_t;

	typedef struct packed {
		logic [2:0] fine_slew_rate2;
		logic slew_disable;
		logic [1:0] amplitude_boost;
		logic [4:0] full_swing_level_rate1;
		logic [2:0] fine_deemph_rate1;
		logic [4:0] full_swing_level_rate2_light;
	} stlc_lane_cfg_t;

	typedef struct packed {
		logic level_apply;
		logic [4:0] level;
		logic deemph_en;
		logic deemph_apply;
		logic [2:0] deemph;
		logic slew_max;
		logic fine_slew_apply;
		logic [2:0] fine_slew;
		logic [1:0] boost;
	} stlc_lane_drv_t;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam stlc_ctrl_t STLC_CTRL_RST = '{low_swing: 1'b0, deemph_select: 1'b0, rate2: 1'b0, lane_select: 4'hf};
	localparam stlc_lane_cfg_t STLC_CFG_RST = '{fine_slew_rate2: 3'h0, slew_disable: 1'b0, amplitude_boost: 2'h1,
		full_swing_level_rate1: 5'h11, fine_deemph_rate1: 3'h4, full_swing_level_rate2_light: 5'h17};

endpackage : stlc_pkg

// [design/stlc_lane_regs.sv]
// Transmit lane control register bank with AXI4-Lite slave and per-lane drive code outputs.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Writes update only lanes chosen by lane_select.
// - Settings persist for all lanes, selected or not.
// - Fine slew rate2, bits 25:23, reset zero.
// - Slew disable forces maximum slew, ignores slew fields.
// - Amplitude boost bits 28:27, reset one, monotonic.
// - Rate1 full-swing level bits 4:0, reset 0x11.
// - Rate1 fine de-emphasis bits 7:5, reset 0x4.
// - Low swing disables de-emphasis on all lanes.
// - Rate2 light level bits 12:8, reset 0x17.
module stlc_lane_regs #(
	parameter int unsigned NUM_LANES = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic soft_reset,
	input wire logic [stlc_pkg::STLC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [stlc_pkg::STLC_DATA_W-1:0] s_axi_wdata,
	input wire logic [stlc_pkg::STLC_STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [stlc_pkg::STLC_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [stlc_pkg::STLC_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output stlc_pkg::stlc_lane_drv_t [NUM_LANES-1:0] tx_drive
);
	import stlc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [STLC_ADDR_W-1:0] awaddr;
		logic [STLC_DATA_W-1:0] wdata;
		logic [STLC_STRB_W-1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [STLC_DATA_W-1:0] rdata;
		stlc_ctrl_t ctrl;
		stlc_lane_cfg_t [NUM_LANES-1:0] cfg;
		stlc_lane_drv_t [NUM_LANES-1:0] drv;
	} stlc_state_t;

	localparam stlc_state_t ST_RST = '{ctrl: STLC_CTRL_RST, cfg: {NUM_LANES{STLC_CFG_RST}}, default: '0};

	stlc_state_t s_r;
	stlc_state_t s_nxt;
	logic wr_fire;
	logic rd_fire;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Byte-lane merge of a write into an existing register image.
	function automatic logic [STLC_DATA_W-1:0] merge_word(input logic [STLC_DATA_W-1:0] old_w,
		input logic [STLC_DATA_W-1:0] new_w, input logic [STLC_STRB_W-1:0] strb);
		logic [STLC_DATA_W-1:0] m;
		m = '0;
		for (int b = 0; b < STLC_STRB_W; b++) begin
			m[b*8 +: 8] = {8{strb[b]}};
		end
		return (old_w & ~m) | (new_w & m);
	endfunction : merge_word

	function automatic logic [STLC_DATA_W-1:0] ctrl_word(input stlc_ctrl_t c);
		logic [STLC_DATA_W-1:0] w;
		w = '0;
		w[STLC_LANE_SEL_LSB +: STLC_LANE_SEL_W] = c.lane_select;
		w[STLC_RATE2_BIT] = c.rate2;
		w[STLC_DEEMPH_SEL_BIT] = c.deemph_select;
		w[STLC_LOW_SWING_BIT] = c.low_swing;
		return w;
	endfunction : ctrl_word

	// Bits 31:29 and everything below the slew fields stay zero here.
	function automatic logic [STLC_DATA_W-1:0] slew_word(input stlc_lane_cfg_t c);
		logic [STLC_DATA_W-1:0] w;
		w = '0;
		w[STLC_FSLEW2_LSB +: $bits(c.fine_slew_rate2)] = c.fine_slew_rate2;
		w[STLC_SLEW_DIS_BIT] = c.slew_disable;
		w[STLC_BOOST_LSB +: $bits(c.amplitude_boost)] = c.amplitude_boost;
		return w;
	endfunction : slew_word

	function automatic logic [STLC_DATA_W-1:0] volt_word(input stlc_lane_cfg_t c);
		logic [STLC_DATA_W-1:0] w;
		w = '0;
		w[STLC_LVL1_LSB +: $bits(c.full_swing_level_rate1)] = c.full_swing_level_rate1;
		w[STLC_DEEMPH1_LSB +: $bits(c.fine_deemph_rate1)] = c.fine_deemph_rate1;
		w[STLC_LVL2_LSB +: $bits(c.full_swing_level_rate2_light)] = c.full_swing_level_rate2_light;
		return w;
	endfunction : volt_word

	function automatic logic [STLC_DATA_W-1:0] status_word(input stlc_lane_drv_t d);
		logic [STLC_DATA_W-1:0] w;
		w = '0;
		w[STLC_ST_LEVEL_LSB +: $bits(d.level)] = d.level;
		w[STLC_ST_DEEMPH_LSB +: $bits(d.deemph)] = d.deemph;
		w[STLC_ST_FSLEW_LSB +: $bits(d.fine_slew)] = d.fine_slew;
		w[STLC_ST_BOOST_LSB +: $bits(d.boost)] = d.boost;
		w[STLC_ST_DEEMPH_EN_BIT] = d.deemph_en;
		w[STLC_ST_SLEW_MAX_BIT] = d.slew_max;
		w[STLC_ST_LEVEL_APPLY_BIT] = d.level_apply;
		w[STLC_ST_FSLEW_APPLY_BIT] = d.fine_slew_apply;
		w[STLC_ST_DEEMPH_APPLY_BIT] = d.deemph_apply;
		return w;
	endfunction : status_word

	// Lowest selected lane is the one that reads back; lane 0 if none selected.
	function automatic int unsigned lane_pick(input logic [STLC_LANE_SEL_W-1:0] sel);
		int unsigned k;
		k = 0;
		for (int i = NUM_LANES - 1; i >= 0; i--) begin
			if (sel[i]) begin
				k = i;
			end
		end
		return k;
	endfunction : lane_pick

	function automatic logic addr_mapped(input logic [STLC_ADDR_W-1:0] a);
		logic [STLC_ADDR_W-1:STLC_WORD_LSB] w;
		w = a[STLC_ADDR_W-1:STLC_WORD_LSB];
		return w == STLC_OFS_LANE_CTRL[STLC_ADDR_W-1:STLC_WORD_LSB] ||
			w == STLC_OFS_SLEW_BOOST[STLC_ADDR_W-1:STLC_WORD_LSB] ||
			w == STLC_OFS_VOLT_DEEMPH[STLC_ADDR_W-1:STLC_WORD_LSB] ||
			w == STLC_OFS_STATUS[STLC_ADDR_W-1:STLC_WORD_LSB];
	endfunction : addr_mapped

	function automatic logic addr_is(input logic [STLC_ADDR_W-1:0] a, input logic [STLC_ADDR_W-1:0] ofs);
		return a[STLC_ADDR_W-1:STLC_WORD_LSB] == ofs[STLC_ADDR_W-1:STLC_WORD_LSB];
	endfunction : addr_is

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [STLC_DATA_W-1:0] img;
		int unsigned pick;
		s_nxt = s_r;
		img = '0;
		pick = lane_pick(s_r.ctrl.lane_select);
		wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
		rd_fire = s_axi_arvalid && s_r.arready;

		// Write address and data are latched independently, in either order.
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end

		// A non-fundamental reset clears only the lane control register.
		if (soft_reset) begin
			s_nxt.ctrl = STLC_CTRL_RST;
		end

		if (wr_fire) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = addr_mapped(s_r.awaddr) ? STLC_RESP_OKAY : STLC_RESP_SLVERR;
			if (addr_is(s_r.awaddr, STLC_OFS_LANE_CTRL)) begin
				img = merge_word(ctrl_word(s_r.ctrl), s_r.wdata, s_r.wstrb);
				s_nxt.ctrl.lane_select = img[STLC_LANE_SEL_LSB +: STLC_LANE_SEL_W];
				s_nxt.ctrl.rate2 = img[STLC_RATE2_BIT];
				s_nxt.ctrl.deemph_select = img[STLC_DEEMPH_SEL_BIT];
				s_nxt.ctrl.low_swing = img[STLC_LOW_SWING_BIT];
			end
			for (int i = 0; i < NUM_LANES; i++) begin
				if (s_r.ctrl.lane_select[i] && addr_is(s_r.awaddr, STLC_OFS_SLEW_BOOST)) begin
					img = merge_word(slew_word(s_r.cfg[i]), s_r.wdata, s_r.wstrb);
					s_nxt.cfg[i].fine_slew_rate2 = img[STLC_FSLEW2_LSB +: 3];
					s_nxt.cfg[i].slew_disable = img[STLC_SLEW_DIS_BIT];
					s_nxt.cfg[i].amplitude_boost = img[STLC_BOOST_LSB +: 2];
				end
				if (s_r.ctrl.lane_select[i] && addr_is(s_r.awaddr, STLC_OFS_VOLT_DEEMPH)) begin
					img = merge_word(volt_word(s_r.cfg[i]), s_r.wdata, s_r.wstrb);
					s_nxt.cfg[i].full_swing_level_rate1 = img[STLC_LVL1_LSB +: 5];
					s_nxt.cfg[i].fine_deemph_rate1 = img[STLC_DEEMPH1_LSB +: 3];
					s_nxt.cfg[i].full_swing_level_rate2_light = img[STLC_LVL2_LSB +: 5];
				end
			end
		end

		// Reads answer one cycle after the address is taken.
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (rd_fire) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = addr_mapped(s_axi_araddr) ? STLC_RESP_OKAY : STLC_RESP_SLVERR;
			if (addr_is(s_axi_araddr, STLC_OFS_LANE_CTRL)) begin
				s_nxt.rdata = ctrl_word(s_r.ctrl);
			end else if (addr_is(s_axi_araddr, STLC_OFS_SLEW_BOOST)) begin
				s_nxt.rdata = slew_word(s_r.cfg[pick]);
			end else if (addr_is(s_axi_araddr, STLC_OFS_VOLT_DEEMPH)) begin
				s_nxt.rdata = volt_word(s_r.cfg[pick]);
			end else begin
				s_nxt.rdata = status_word(s_r.drv[pick]);
			end
		end

		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;

		// Drive codes per lane from the stored settings and the port mode.
		for (int i = 0; i < NUM_LANES; i++) begin
			s_nxt.drv[i].boost = s_r.cfg[i].amplitude_boost;
			s_nxt.drv[i].slew_max = s_r.cfg[i].slew_disable;
			s_nxt.drv[i].fine_slew_apply = s_r.ctrl.rate2 && !s_r.cfg[i].slew_disable;
			s_nxt.drv[i].fine_slew = s_nxt.drv[i].fine_slew_apply ? s_r.cfg[i].fine_slew_rate2 : '0;
			s_nxt.drv[i].deemph_en = !s_r.ctrl.low_swing;
			s_nxt.drv[i].deemph_apply = !s_r.ctrl.low_swing && !s_r.ctrl.rate2;
			s_nxt.drv[i].deemph = s_nxt.drv[i].deemph_apply ? s_r.cfg[i].fine_deemph_rate1 : '0;
			s_nxt.drv[i].level_apply = !s_r.ctrl.low_swing &&
				(!s_r.ctrl.rate2 || s_r.ctrl.deemph_select == STLC_DEEMPH_3P5DB);
			s_nxt.drv[i].level = s_r.ctrl.rate2 ? s_r.cfg[i].full_swing_level_rate2_light
				: s_r.cfg[i].full_swing_level_rate1;
		end
	end

	// Only the fundamental reset returns the sticky lane settings to their defaults.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = s_r.rdata;
	assign tx_drive = s_r.drv;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_slew_write;
		wr_fire && addr_is(s_r.awaddr, STLC_OFS_SLEW_BOOST) && !soft_reset;
	endsequence

	sequence s_volt_write;
		wr_fire && addr_is(s_r.awaddr, STLC_OFS_VOLT_DEEMPH);
	endsequence

	for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane_chk
		a_unsel_lane_hold: assert property (@(posedge aclk) disable iff (!aresetn)
			s_volt_write and !s_r.ctrl.lane_select[g] |=> $stable(s_r.cfg[g]))
			else $error("unselected lane setting changed on write");
		a_sel_lane_take: assert property (@(posedge aclk) disable iff (!aresetn)
			s_slew_write and s_r.ctrl.lane_select[g] && s_r.wstrb[3] |=>
			s_r.cfg[g].amplitude_boost == $past(s_r.wdata[STLC_BOOST_LSB +: 2]))
			else $error("selected lane did not take boost write");
		a_fslew_rate2_apply: assert property (@(posedge aclk) disable iff (!aresetn)
			s_r.ctrl.rate2 && !s_r.cfg[g].slew_disable |=> s_r.drv[g].fine_slew_apply &&
			s_r.drv[g].fine_slew == $past(s_r.cfg[g].fine_slew_rate2))
			else $error("rate2 fine slew not applied");
	end

	a_fslew_reset_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> s_r.cfg[0].fine_slew_rate2 == 3'h0 && s_r.cfg[0].amplitude_boost == 2'h1)
		else $error("slew or boost reset value wrong");

	a_slew_max_force: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.cfg[0].slew_disable |=> s_r.drv[0].slew_max && !s_r.drv[0].fine_slew_apply && s_r.drv[0].fine_slew == 3'h0)
		else $error("slew disable did not force maximum slew");

	a_boost_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn |=> s_r.drv[0].boost == $past(s_r.cfg[0].amplitude_boost))
		else $error("boost code not applied");

	a_level_rate1_pick: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && !s_r.ctrl.rate2 && !s_r.ctrl.low_swing |=> s_r.drv[0].level_apply &&
		s_r.drv[0].level == $past(s_r.cfg[0].full_swing_level_rate1))
		else $error("rate1 level not applied");

	a_deemph_rate1_pick: assert property (@(posedge aclk) disable iff (!aresetn)
		aresetn && !s_r.ctrl.rate2 && !s_r.ctrl.low_swing |=> s_r.drv[0].deemph == $past(s_r.cfg[0].fine_deemph_rate1))
		else $error("rate1 fine de-emphasis not applied");

	a_low_swing_off: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.ctrl.low_swing [*2] |-> !s_r.drv[0].deemph_en && s_r.drv[0].deemph == 3'h0 && !s_r.drv[0].level_apply)
		else $error("de-emphasis active in low swing");

	a_level_rate2_light: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.ctrl.rate2 && !s_r.ctrl.low_swing |=> s_r.drv[0].level_apply ==
		($past(s_r.ctrl.deemph_select) == STLC_DEEMPH_3P5DB) &&
		s_r.drv[0].level == $past(s_r.cfg[0].full_swing_level_rate2_light))
		else $error("rate2 level selection wrong");

	a_resv_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_fire && addr_is(s_axi_araddr, STLC_OFS_SLEW_BOOST) |=> s_axi_rvalid && s_axi_rdata[31:29] == 3'h0)
		else $error("reserved bits read nonzero");

	a_sticky_soft: assert property (@(posedge aclk) disable iff (!aresetn)
		soft_reset && !wr_fire |=> $stable(s_r.cfg) && s_r.ctrl == STLC_CTRL_RST)
		else $error("soft reset disturbed sticky settings");

	a_rate2_deemph_off: assert property (@(posedge aclk) disable iff (!aresetn)
		s_r.ctrl.rate2 |=> !s_r.drv[0].deemph_apply && s_r.drv[0].deemph == 3'h0)
		else $error("rate1 de-emphasis applied at rate2");

	a_wr_resp_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid && s_axi_bresp == STLC_RESP_OKAY)
		else $error("write response missing after write");

endmodule : stlc_lane_regs

// [sim/tb.sv]
// Self-checking testbench for the transmit lane control register bank.
`timescale 1ns/1ps

module tb;
	import stlc_pkg::*;

	// ----------------------------------------------------------------
	// Clock, reset, bus signals and the design
	// ----------------------------------------------------------------
	logic aclk, aresetn, soft_reset;
	logic [3:0] awaddr, araddr, wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	stlc_lane_drv_t [3:0] tx_drive;
	int n_fail = 0;
	int total_checks = 0;

	stlc_lane_regs #(.NUM_LANES(4)) u_dut (.aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tx_drive(tx_drive));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && n < 100) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				done = 1;
				bready <= 1'b0;
				chk({30'h0, bresp}, {30'h0, STLC_RESP_OKAY}, "write response");
			end
		end
		if (!done) chk(32'h0, 32'h1, "write never answered");
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && n < 100) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				done = 1;
				rready <= 1'b0;
				chk(rdata, exp, "read data");
				chk({30'h0, rresp}, {30'h0, STLC_RESP_OKAY}, "read response");
			end
		end
		if (!done) chk(32'h0, 32'h1, "read never answered");
	endtask : rd

	function automatic logic [31:0] drv(input logic la, input logic [4:0] lv, input logic de, input logic da,
		input logic [2:0] d, input logic sm, input logic fa, input logic [2:0] f, input logic [1:0] b);
		stlc_lane_drv_t v;
		v = '{level_apply: la, level: lv, deemph_en: de, deemph_apply: da, deemph: d, slew_max: sm,
			fine_slew_apply: fa, fine_slew: f, boost: b};
		return {14'h0, v};
	endfunction : drv

	task automatic lane(input int i, input logic [31:0] exp, input string msg);
		repeat (3) @(posedge aclk);
		chk({14'h0, tx_drive[i]}, exp, msg);
	endtask : lane

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// Test sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		soft_reset = 1'b0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(STLC_OFS_LANE_CTRL, 32'h0000000f);
		rd(STLC_OFS_SLEW_BOOST, 32'h08000000);
		rd(STLC_OFS_VOLT_DEEMPH, 32'h00001791);
		lane(3, drv(1, 5'h11, 1, 1, 3'h4, 0, 0, 3'h0, 2'h1), "reset drive");
		$display("test reset values done");
		wr(STLC_OFS_LANE_CTRL, 32'h00000001);
		wr(STLC_OFS_VOLT_DEEMPH, 32'hffffffff);
		wr(STLC_OFS_SLEW_BOOST, 32'hffffffff);
		rd(STLC_OFS_VOLT_DEEMPH, 32'h00001fff);
		rd(STLC_OFS_SLEW_BOOST, 32'h1f800000);
		lane(0, drv(1, 5'h1f, 1, 1, 3'h7, 1, 0, 3'h0, 2'h3), "selected lane");
		lane(1, drv(1, 5'h11, 1, 1, 3'h4, 0, 0, 3'h0, 2'h1), "unselected lane");
		$display("test lane select done");
		wr(STLC_OFS_LANE_CTRL, 32'h00000011);
		lane(0, drv(0, 5'h1f, 1, 0, 3'h0, 1, 0, 3'h0, 2'h3), "rate2 slew disabled");
		lane(1, drv(0, 5'h17, 1, 0, 3'h0, 0, 1, 3'h0, 2'h1), "rate2 fine slew");
		wr(STLC_OFS_LANE_CTRL, 32'h00000031);
		lane(0, drv(1, 5'h1f, 1, 0, 3'h0, 1, 0, 3'h0, 2'h3), "rate2 light level");
		lane(1, drv(1, 5'h17, 1, 0, 3'h0, 0, 1, 3'h0, 2'h1), "rate2 light reset");
		wr(STLC_OFS_LANE_CTRL, 32'h00000041);
		lane(0, drv(0, 5'h1f, 0, 0, 3'h0, 1, 0, 3'h0, 2'h3), "low swing lane0");
		lane(1, drv(0, 5'h11, 0, 0, 3'h0, 0, 0, 3'h0, 2'h1), "low swing lane1");
		$display("test modes done");
		wr(STLC_OFS_LANE_CTRL, 32'h00000012);
		for (int k = 0; k < 4; k++) begin
			wr(STLC_OFS_SLEW_BOOST, 32'h02800000 | (32'(k) << 27));
			rd(STLC_OFS_SLEW_BOOST, 32'h02800000 | (32'(k) << 27));
			lane(1, drv(0, 5'h17, 1, 0, 3'h0, 0, 1, 3'h5, k[1:0]), "boost code");
			lane(0, drv(0, 5'h1f, 1, 0, 3'h0, 1, 0, 3'h0, 2'h3), "other lane boost");
		end
		wstrb <= 4'h8;
		wr(STLC_OFS_SLEW_BOOST, 32'h00000000);
		wstrb <= 4'hf;
		rd(STLC_OFS_SLEW_BOOST, 32'h00800000);
		lane(1, drv(0, 5'h17, 1, 0, 3'h0, 0, 1, 3'h1, 2'h0), "byte strobe merge");
		$display("test boost codes done");
		@(posedge aclk);
		soft_reset <= 1'b1;
		@(posedge aclk);
		soft_reset <= 1'b0;
		rd(STLC_OFS_LANE_CTRL, 32'h0000000f);
		rd(STLC_OFS_VOLT_DEEMPH, 32'h00001fff);
		rd(STLC_OFS_STATUS, 32'h0002f8ff);
		lane(0, drv(1, 5'h1f, 1, 1, 3'h7, 1, 0, 3'h0, 2'h3), "sticky lane0");
		$display("test soft reset done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(STLC_OFS_VOLT_DEEMPH, 32'h00001791);
		rd(STLC_OFS_SLEW_BOOST, 32'h08000000);
		$display("test fundamental reset done");
		test_done();
	end

	initial begin
		#(4 * 20000);
		n_fail++;
		$display("FAIL t=%0t watchdog expired", $time);
		test_done();
	end

endmodule : tb
